/* core/clpm_pkg.sv */
// Package for the link performance monitor: register map, fields, timing counts
// Assumes a 32-bit APB slave and a 250 MHz system clock
package clpm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CLPM_OFS_CTRL      = 8'h00;
  localparam logic [7:0] CLPM_OFS_CMD       = 8'h04;
  localparam logic [7:0] CLPM_OFS_USR_CRC   = 8'h08;
  localparam logic [7:0] CLPM_OFS_USR_FWE   = 8'h0C;
  localparam logic [7:0] CLPM_OFS_USR_ES    = 8'h10;
  localparam logic [7:0] CLPM_OFS_USR_ESH   = 8'h14;
  localparam logic [7:0] CLPM_OFS_USR_FRZT  = 8'h18;
  localparam logic [7:0] CLPM_OFS_NET_CRC   = 8'h1C;
  localparam logic [7:0] CLPM_OFS_NET_ES    = 8'h20;
  localparam logic [7:0] CLPM_OFS_NET_ESH   = 8'h24;
  localparam logic [7:0] CLPM_OFS_NET_FRZT  = 8'h28;
  localparam logic [7:0] CLPM_OFS_SEC       = 8'h2C;
  localparam logic [7:0] CLPM_OFS_TOD       = 8'h30;
  localparam logic [7:0] CLPM_OFS_IRQ_STAT  = 8'h34;
  localparam logic [7:0] CLPM_OFS_IRQ_EN    = 8'h38;
  localparam logic [7:0] CLPM_OFS_IRQ_CLR   = 8'h3C;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int CLPM_CTRL_CRC_EN   = 0;
  localparam int CLPM_CTRL_USR_FRZ  = 1;
  localparam int CLPM_CMD_CLR_EV    = 0;
  localparam int CLPM_CMD_CLR_ALL   = 1;
  localparam int CLPM_IRQ_CRC       = 0;
  localparam int CLPM_IRQ_FWE       = 1;
  localparam int CLPM_IRQ_ES        = 2;
  localparam int CLPM_IRQ_INTV      = 3;
  localparam int CLPM_IRQ_W         = 4;
  localparam logic [1:0] CLPM_CTRL_RST = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLPM_CLK_HZ        = 250_000_000;
  localparam int CLPM_SEC_S         = 1;
  localparam int CLPM_SEC_CYC       = CLPM_CLK_HZ * CLPM_SEC_S;
  localparam int CLPM_INTV_MIN      = 15;
  localparam int CLPM_INTV_TICKS    = CLPM_INTV_MIN * 60;
  localparam int CLPM_TICK_W        = 10;

endpackage

/* core/clpm_top.sv */
// Link performance monitor: CRC4 and frame-word error counts, errored seconds
// Assumes framer event pulses on the system clock and an APB master
//
// Function
// RQ1 - CRC4 events count only while CRC4 is enabled in the frame-zero slot.
// RQ2 - Sender appends CRC4; framer recomputes and pulses mismatch events here.
// RQ3 - CRC4 count clears on event-clear or clear-all command.
// RQ4 - Each single bad frame alignment word adds one to frame error count.
// RQ5 - Frame error count is user-readable only; cleared by either clear.
// RQ6 - Each second, any event in that second adds one errored second.
// RQ7 - Errored seconds run 15 minutes, then go to history and restart.
// RQ8 - Current errored seconds clear on clear-all only.
// RQ9 - Separate user and provider banks of counters are kept.
// RQ10 - User controls affect user bank; provider bank controlled from network only. The user CRC4 enable in CTRL gates CRC4 events for both banks.
// RQ11 - Each CRC4 error counts as exactly one bit error.
// RQ12 - Freeze holds every counter and records time of day it began.
// RQ13 - Interval boundary is 900 one-second ticks of the same time base.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps

module clpm_top #(
  parameter int SEC_CYC = clpm_pkg::CLPM_SEC_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crc_err_ev,
  input  wire logic        fwe_err_ev,
  input  wire logic        net_clr_ev,
  input  wire logic        net_clr_all,
  input  wire logic        net_freeze,
  output logic [31:0]      net_crc_cnt,
  output logic [31:0]      net_es_cnt,
  output logic [31:0]      net_es_hist,
  output logic             irq
);
  import clpm_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Network-side control synchronisers
  // ----------------------------------------------------------------
  logic [2:0] net_s1_q;
  logic [2:0] net_s2_q;
  logic [2:0] net_s3_q;
  logic       net_clr_ev_p;
  logic       net_clr_all_p;
  logic       net_frz;

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      net_s1_q <= 3'h0;
      net_s2_q <= 3'h0;
      net_s3_q <= 3'h0;
    end
    else
    begin
      net_s1_q <= {net_freeze, net_clr_all, net_clr_ev};
      net_s2_q <= net_s1_q;
      net_s3_q <= net_s2_q;
    end
  end

  // Clears act on a rising edge of the synchronised copy; freeze is a level
  assign net_clr_ev_p  = net_s2_q[0] & ~net_s3_q[0];
  assign net_clr_all_p = net_s2_q[1] & ~net_s3_q[1];
  assign net_frz       = net_s2_q[2];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  localparam int IRQ_W_C = CLPM_IRQ_W;
  logic [1:0]  ctrl_q;
  logic [IRQ_W_C-1:0] irq_en_q;
  logic        wr_en;
  logic        usr_clr_ev;
  logic        usr_clr_all;
  logic [IRQ_W_C-1:0] irq_clr;

  // Write strobe for one register offset
  function automatic logic wr_hit(
    input logic       we,
    input logic [7:0] adr,
    input logic [7:0] ofs
  );
    return we && (adr == ofs);
  endfunction

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;
  assign usr_clr_ev  = wr_hit(wr_en, paddr, CLPM_OFS_CMD) && pwdata[CLPM_CMD_CLR_EV];
  assign usr_clr_all = wr_hit(wr_en, paddr, CLPM_OFS_CMD) && pwdata[CLPM_CMD_CLR_ALL];
  assign irq_clr = wr_hit(wr_en, paddr, CLPM_OFS_IRQ_CLR) ? pwdata[IRQ_W_C-1:0]
                                                         : {IRQ_W_C{1'b0}};

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      ctrl_q <= CLPM_CTRL_RST;
    else if (wr_hit(wr_en, paddr, CLPM_OFS_CTRL))
      ctrl_q <= pwdata[1:0];
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      irq_en_q <= {IRQ_W_C{1'b0}};
    else if (wr_hit(wr_en, paddr, CLPM_OFS_IRQ_EN))
      irq_en_q <= pwdata[IRQ_W_C-1:0];
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  logic [27:0]            div_q;
  logic                   sec_tick;
  logic [CLPM_TICK_W-1:0] sec_q;
  logic                   intv_end;
  logic [31:0]            tod_q;

  assign sec_tick = div_q == 28'(SEC_CYC - 1);
  assign intv_end = sec_tick && sec_q == CLPM_TICK_W'(CLPM_INTV_TICKS - 1);

  // Divider: one-cycle tick every SEC_CYC clocks
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      div_q <= 28'h000_0000;
    else
      div_q <= sec_tick ? 28'h000_0000 : div_q + 28'h000_0001;
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sec_q <= {CLPM_TICK_W{1'b0}};
      tod_q <= 32'h0000_0000;
    end
    else if (sec_tick)
    begin
      tod_q <= tod_q + 32'h0000_0001;
      sec_q <= intv_end ? {CLPM_TICK_W{1'b0}} : sec_q + CLPM_TICK_W'(1); // RQ13
    end
  end

  // ----------------------------------------------------------------
  // Qualified events
  // ----------------------------------------------------------------
  logic crc_ev;

  // RQ2: framer delivers mismatch pulses; gated by enable here
  assign crc_ev = crc_err_ev & ctrl_q[CLPM_CTRL_CRC_EN]; // RQ1 RQ2

  // ----------------------------------------------------------------
  // Counter banks: index 0 user, 1 provider
  // ----------------------------------------------------------------
  logic [1:0]  clr_ev_b;
  logic [1:0]  clr_all_b;
  logic [1:0]  frz_b;
  logic [1:0]  frz_d1_q;
  logic [1:0]  es_inc;
  logic [31:0] crc_cnt_q  [2];
  logic [31:0] fwe_cnt_q  [2];
  logic [31:0] es_cnt_q   [2];
  logic [31:0] es_hist_q  [2];
  logic [31:0] frz_tod_q  [2];
  logic [1:0]  sec_ev_q;

  assign clr_ev_b  = {net_clr_ev_p, usr_clr_ev};  // RQ10
  assign clr_all_b = {net_clr_all_p, usr_clr_all}; // RQ10
  assign frz_b     = {net_frz, ctrl_q[CLPM_CTRL_USR_FRZ]}; // RQ10

  generate
    for (genvar b = 0; b < 2; b++) // RQ9
    begin : g_bank
      always_ff @(posedge clock or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          crc_cnt_q[b] <= 32'h0000_0000;
          fwe_cnt_q[b] <= 32'h0000_0000;
        end
        else if (clr_ev_b[b] || clr_all_b[b])
        begin
          crc_cnt_q[b] <= 32'h0000_0000; // RQ3
          fwe_cnt_q[b] <= 32'h0000_0000; // RQ5
        end
        else if (!frz_b[b]) // RQ12
        begin
          if (crc_ev)
            crc_cnt_q[b] <= crc_cnt_q[b] + 32'h0000_0001; // RQ11
          if (fwe_err_ev)
            fwe_cnt_q[b] <= fwe_cnt_q[b] + 32'h0000_0001; // RQ4
        end
      end

      // Event seen within the current second. An event on the tick cycle is
      // already counted by es_inc, so the tick clears it; otherwise an event
      // wins over a clear-all in the same cycle. A frozen bank ignores events.
      always_ff @(posedge clock or negedge rst_n_q)
      begin
        if (!rst_n_q)
          sec_ev_q[b] <= 1'b0;
        else if ((crc_ev || fwe_err_ev) && !sec_tick && !frz_b[b])
          sec_ev_q[b] <= 1'b1;
        else if (sec_tick || clr_all_b[b])
          sec_ev_q[b] <= 1'b0;
      end

      assign es_inc[b] = sec_tick && !frz_b[b] && (sec_ev_q[b] || crc_ev || fwe_err_ev); // RQ6

      always_ff @(posedge clock or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          es_cnt_q[b]  <= 32'h0000_0000;
          es_hist_q[b] <= 32'h0000_0000;
        end
        else if (clr_all_b[b])
        begin
          es_cnt_q[b]  <= 32'h0000_0000; // RQ8
          es_hist_q[b] <= 32'h0000_0000;
        end
        else if (intv_end && !frz_b[b])
        begin
          es_hist_q[b] <= es_cnt_q[b] + {31'h0000_0000, es_inc[b]}; // RQ7
          es_cnt_q[b]  <= 32'h0000_0000; // RQ7
        end
        else if (es_inc[b])
          es_cnt_q[b] <= es_cnt_q[b] + 32'h0000_0001; // RQ6
      end

      always_ff @(posedge clock or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          frz_d1_q[b]  <= 1'b0;
          frz_tod_q[b] <= 32'h0000_0000;
        end
        else
        begin
          frz_d1_q[b] <= frz_b[b];
          if (frz_b[b] && !frz_d1_q[b])
            frz_tod_q[b] <= tod_q; // RQ12
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Provider bank toward the network side
  // ----------------------------------------------------------------
  // Frame error count is not offered here
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      net_crc_cnt <= 32'h0000_0000;
      net_es_cnt  <= 32'h0000_0000;
      net_es_hist <= 32'h0000_0000;
    end
    else
    begin
      net_crc_cnt <= crc_cnt_q[1];
      net_es_cnt  <= es_cnt_q[1];
      net_es_hist <= es_hist_q[1]; // RQ5
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W_C-1:0] irq_st_q;
  logic [IRQ_W_C-1:0] irq_set;

  assign irq_set = {intv_end, es_inc[0], fwe_err_ev, crc_ev};

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      irq_st_q <= {IRQ_W_C{1'b0}};
    else
      irq_st_q <= irq_set | (irq_st_q & ~irq_clr);
  end

  assign irq = |(irq_st_q & irq_en_q);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      CLPM_OFS_CTRL:     prdata = {30'h0000_0000, ctrl_q};
      CLPM_OFS_USR_CRC:  prdata = crc_cnt_q[0];
      CLPM_OFS_USR_FWE:  prdata = fwe_cnt_q[0]; // RQ5
      CLPM_OFS_USR_ES:   prdata = es_cnt_q[0];
      CLPM_OFS_USR_ESH:  prdata = es_hist_q[0];
      CLPM_OFS_USR_FRZT: prdata = frz_tod_q[0];
      CLPM_OFS_NET_CRC:  prdata = crc_cnt_q[1];
      CLPM_OFS_NET_ES:   prdata = es_cnt_q[1];
      CLPM_OFS_NET_ESH:  prdata = es_hist_q[1];
      CLPM_OFS_NET_FRZT: prdata = frz_tod_q[1];
      CLPM_OFS_SEC:      prdata = {22'h00_0000, sec_q};
      CLPM_OFS_TOD:      prdata = tod_q;
      CLPM_OFS_IRQ_STAT: prdata = {28'h000_0000, irq_st_q};
      CLPM_OFS_IRQ_EN:   prdata = {28'h000_0000, irq_en_q};
      default:           prdata = 32'h0000_0000;
    endcase
  end

endmodule

/* dv/clpm_framer_model.sv */
// Receive framer stand-in driving CRC4 and frame word error pulses
// Assumes calls start just after a rising clock edge
`timescale 1ns/1ps
module clpm_framer_model (
  input wire logic clock,
  output logic     crc_err_ev,
  output logic     fwe_err_ev
);
  initial
  begin
    crc_err_ev = 1'b0;
    fwe_err_ev = 1'b0;
  end
  // One-cycle pulse after gap+1 idle cycles; c flags a CRC4 miscompare
  task pulse(input logic c, input logic f, input int gap);
    repeat (gap + 1) @(posedge clock);
    crc_err_ev <= c;
    fwe_err_ev <= f;
    @(posedge clock);
    crc_err_ev <= 1'b0;
    fwe_err_ev <= 1'b0;
  endtask
endmodule

/* dv/clpm_props.sv */
// Checker for the monitor's APB answer and provider-bank outputs
// Assumes binding into clpm_top
`timescale 1ns/1ps
module clpm_props (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        crc_err_ev,
  input wire logic        net_clr_ev,
  input wire logic        net_clr_all,
  input wire logic        net_freeze,
  input wire logic [31:0] net_crc_cnt,
  input wire logic [31:0] net_es_cnt,
  input wire logic [31:0] net_es_hist
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_apb_ready: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb access stalled");
  a_crc_step: assert property ($changed(net_crc_cnt) |->
    net_crc_cnt == $past(net_crc_cnt) + 32'h1 || net_crc_cnt == 32'h0)
    else $error("crc count jumped");
  a_crc_cause: assert property (net_crc_cnt == $past(net_crc_cnt) + 32'h1 |->
    $past(crc_err_ev, 1) || $past(crc_err_ev, 2) || $past(crc_err_ev, 3))
    else $error("crc count without event");
  a_es_step: assert property ($changed(net_es_cnt) |->
    net_es_cnt == $past(net_es_cnt) + 32'h1 || net_es_cnt == 32'h0)
    else $error("errored seconds jumped");
  a_es_bound: assert property (net_es_cnt <= 32'h0000_0384)
    else $error("errored seconds past interval");
  a_frz_hold: assert property ((net_freeze && !net_clr_ev && !net_clr_all)[*8] |=>
    $stable(net_crc_cnt) && $stable(net_es_cnt))
    else $error("count moved while frozen");
  a_clr_ev: assert property ($rose(net_clr_ev) |-> ##[1:8] net_crc_cnt == 32'h0)
    else $error("event clear missed");
  a_clr_all: assert property ($rose(net_clr_all) |-> ##[1:8]
    (net_crc_cnt == 32'h0 && net_es_cnt == 32'h0 && net_es_hist == 32'h0))
    else $error("clear all missed");
  a_hist_wrap: assert property (net_es_cnt == 32'h0 && $past(net_es_cnt) != 32'h0 &&
    !net_clr_all && !$past(net_clr_all) |-> net_es_hist == $past(net_es_cnt) ||
    net_es_hist == $past(net_es_cnt) + 32'h1)
    else $error("history not kept");
endmodule

bind clpm_top clpm_props u_props (.clock(clock), .nrst(nrst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .crc_err_ev(crc_err_ev),
  .net_clr_ev(net_clr_ev), .net_clr_all(net_clr_all), .net_freeze(net_freeze),
  .net_crc_cnt(net_crc_cnt), .net_es_cnt(net_es_cnt), .net_es_hist(net_es_hist));

/* dv/clpm_top_test.sv */
// Bench for the link performance monitor: APB tasks, directed scenarios
// Assumes a 20-cycle second and the framer model beside the design
`timescale 1ns/1ps
module clpm_top_test;
  import clpm_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        net_clr_ev = 1'b0;
  logic        net_clr_all = 1'b0;
  logic        net_freeze = 1'b0;
  logic [31:0] prdata, net_crc_cnt, net_es_cnt, net_es_hist, v, t;
  logic        pready, pslverr, crc_err_ev, fwe_err_ev, irq;
  int          miscompares = 0;
  int          n_compared = 0;
  int          i;
  always #2 clock = ~clock;
  clpm_top #(.SEC_CYC(20)) DUT (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .crc_err_ev(crc_err_ev),
    .fwe_err_ev(fwe_err_ev), .net_clr_ev(net_clr_ev), .net_clr_all(net_clr_all),
    .net_freeze(net_freeze), .net_crc_cnt(net_crc_cnt), .net_es_cnt(net_es_cnt),
    .net_es_hist(net_es_hist), .irq(irq));
  clpm_framer_model fr (.clock(clock), .crc_err_ev(crc_err_ev), .fwe_err_ev(fwe_err_ev));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task ck(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
    begin
      miscompares++;
      end_sim();
    end
    v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    ck(v, e);
  endtask
  // Returns just after the seconds count moves on
  task wait_sec();
    logic [31:0] s;
    int k;
    xfer(1'b0, CLPM_OFS_SEC, 32'h0000_0000);
    s = v;
    k = 0;
    do
    begin
      xfer(1'b0, CLPM_OFS_SEC, 32'h0000_0000);
      k++;
    end while (v === s && k < 20);
    if (v === s)
    begin
      ck(v, ~s);
      end_sim();
    end
  endtask
  task ev(input logic c, input logic f, input int n);
    repeat (n) fr.pulse(c, f, 0);
    repeat (4) @(posedge clock);
  endtask
  task netp(input logic all);
    if (all)
      net_clr_all <= 1'b1;
    else
      net_clr_ev <= 1'b1;
    repeat (10) @(posedge clock);
    net_clr_ev <= 1'b0;
    net_clr_all <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task cki(input logic e);
    repeat (2) @(posedge clock);
    ck({31'h0, irq}, {31'h0, e});
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    rd(CLPM_OFS_CTRL, 32'h0000_0000);
    xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    ev(1'b1, 1'b0, 2);
    rd(CLPM_OFS_USR_CRC, 32'h0000_0000);
    ck(net_crc_cnt, 32'h0000_0000);
    xfer(1'b1, CLPM_OFS_CTRL, 32'h0000_0001);
    ev(1'b1, 1'b1, 2);
    ev(1'b1, 1'b0, 1);
    rd(CLPM_OFS_USR_CRC, 32'h0000_0003);
    rd(CLPM_OFS_USR_FWE, 32'h0000_0002);
    ck(net_crc_cnt, 32'h0000_0003);
    xfer(1'b1, CLPM_OFS_CMD, 32'h0000_0001);
    rd(CLPM_OFS_USR_CRC, 32'h0000_0000);
    rd(CLPM_OFS_USR_FWE, 32'h0000_0000);
    ck(net_crc_cnt, 32'h0000_0003);
    netp(1'b0);
    ck(net_crc_cnt, 32'h0000_0000);
    repeat (25) @(posedge clock);
    xfer(1'b1, CLPM_OFS_CMD, 32'h0000_0002);
    rd(CLPM_OFS_USR_ES, 32'h0000_0000);
    wait_sec();
    ev(1'b1, 1'b0, 2);
    repeat (25) @(posedge clock);
    rd(CLPM_OFS_USR_ES, 32'h0000_0001);
    rd(CLPM_OFS_IRQ_STAT, 32'h0000_0007);
    xfer(1'b1, CLPM_OFS_CMD, 32'h0000_0001);
    rd(CLPM_OFS_USR_ES, 32'h0000_0001);
    xfer(1'b1, CLPM_OFS_CMD, 32'h0000_0002);
    rd(CLPM_OFS_USR_ES, 32'h0000_0000);
    ev(1'b1, 1'b0, 1);
    repeat (25) @(posedge clock);
    xfer(1'b1, CLPM_OFS_IRQ_CLR, 32'h0000_000F);
    xfer(1'b1, CLPM_OFS_IRQ_EN, 32'h0000_0008);
    i = 0;
    while (irq !== 1'b1 && i < 20000)
    begin
      @(posedge clock);
      i++;
    end
    cki(1'b1);
    if (irq !== 1'b1)
      end_sim();
    rd(CLPM_OFS_USR_ESH, 32'h0000_0001);
    rd(CLPM_OFS_USR_ES, 32'h0000_0000);
    rd(CLPM_OFS_SEC, 32'h0000_0000);
    xfer(1'b1, CLPM_OFS_IRQ_CLR, 32'h0000_000F);
    xfer(1'b1, CLPM_OFS_IRQ_EN, 32'h0000_0001);
    cki(1'b0);
    ev(1'b1, 1'b0, 1);
    cki(1'b1);
    xfer(1'b1, CLPM_OFS_IRQ_EN, 32'h0000_0000);
    cki(1'b0);
    xfer(1'b1, CLPM_OFS_IRQ_EN, 32'h0000_0001);
    cki(1'b1);
    xfer(1'b1, CLPM_OFS_IRQ_CLR, 32'h0000_0001);
    cki(1'b0);
    wait_sec();
    xfer(1'b0, CLPM_OFS_TOD, 32'h0000_0000);
    t = v;
    xfer(1'b1, CLPM_OFS_CTRL, 32'h0000_0003);
    ev(1'b1, 1'b0, 2);
    rd(CLPM_OFS_USR_CRC, 32'h0000_0002);
    rd(CLPM_OFS_USR_FRZT, t);
    ck(net_crc_cnt, 32'h0000_0006);
    net_freeze <= 1'b1;
    repeat (8) @(posedge clock);
    ev(1'b1, 1'b0, 1);
    ck(net_crc_cnt, 32'h0000_0006);
    net_freeze <= 1'b0;
    netp(1'b1);
    ck(net_es_hist, 32'h0000_0000);
    ck(net_crc_cnt, 32'h0000_0000);
    end_sim();
  end
endmodule
